/* File: motor_pwm_time_base.sv */
// Purpose: Motor PWM time base, trigger, pin mode, enables, buffering and override.
// Assumes: clk_i runs at twice the instruction rate, so one clk_i is half a cycle.
// Notes: Wishbone classic slave, 32-bit data, 16-bit registers in the low bits.
//
// What this block does
// (RULE_01) Output edges placed at half-instruction-cycle resolution from a dedicated time base.
// (RULE_02) Each generator drives a high and low pin, complementary or independent.
// (RULE_03) Time base offers edge, center, center double-update and single event modes.
// (RULE_04) Counter register holds a readable and writable 15-bit count.
// (RULE_05) Counter register top bit reads direction, 1 counting down.
// (RULE_06) Period register holds 15 writable bits; top bit reads zero.
// (RULE_07) Special event trigger fires when count equals the compare value.
// (RULE_08) Trigger fires only when count direction matches the compare direction bit.
// (RULE_09) Special event trigger goes out to the converter to start conversions.
// (RULE_10) Four pair mode bits pick independent (1) or complementary (0) pairs.
// (RULE_11) Per-pin enables hand pins to the generator or release them to GPIO.
// (RULE_12) Pin enable reset values come from a nonvolatile configuration bit.
// (RULE_13) Three configuration bits set pin reset state and active polarity.
// (RULE_14) Buffer transfer block bit stops duty and period buffer copies.
// (RULE_15) A control bit makes duty writes immediate or wait for the boundary.
// (RULE_16) Manual override register lets software force each output pin.
// (RULE_17) Larger variant has four generators, smaller has three.
// (RULE_18) Time base counts only when enabled, and halts in idle if asked.
// (RULE_19) Mode field: 00 free, 01 single, 10 up/down, 11 double update.
// (RULE_20) Prescaler 1,4,16,64; postscalers 1:1 to 1:16 for both events.
// (RULE_21) Override sync bit makes overrides immediate or wait for the boundary.
//
// The Wishbone register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "motor_pwm_params.svh"

module motor_pwm_time_base #(
	parameter int NUM_GEN = 4
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave.
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// System state and configuration.
	input wire logic idle_i,
	input wire motor_pwm_pkg::boot_config_word_t boot_config_word_i,
	// Pins and events.
	output motor_pwm_pkg::pin_pair_t pin_level_o,
	output motor_pwm_pkg::pin_pair_t pin_own_o,
	output logic adc_trigger_o,
	output logic period_event_o
);

	logic [15:0] ctrl_q;
	logic [14:0] count_q;
	logic dir_q;
	logic [15:0] period_buf_q;
	logic [14:0] period_act_q;
	logic [15:0] cmp_q;
	logic [15:0] pincfg_q;
	logic [15:0] upd_q;
	logic [15:0] ovr_q;
	logic [15:0] ovr_act_q;
	logic [15:0] duty_buf_q [4];
	logic [15:0] duty_act_q [4];
	logic phase_q;
	logic [5:0] pre_q;
	logic [3:0] tb_post_q;
	logic [3:0] sev_post_q;
	logic ack_q;
	logic [31:0] dat_q;
	motor_pwm_pkg::pin_pair_t level_q;
	motor_pwm_pkg::pin_pair_t own_q;
	logic adc_q;
	logic per_evt_q;

	logic req;
	logic wr;
	logic wr_ctrl;
	logic wr_count;
	logic wr_period;
	logic wr_cmp;
	logic wr_pincfg;
	logic wr_upd;
	logic wr_ovr;
	logic [3:0] wr_duty;
	logic run;
	logic [5:0] pre_limit;
	logic tb_tick;
	logic at_top;
	logic at_bot;
	logic boundary;
	logic sev_match;
	motor_pwm_pkg::count_mode_t mode;
	logic [15:0] rd_word;

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		merge = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
	endfunction : merge

	assign req = cyc_i && stb_i && !ack_q;
	assign wr = req && we_i;
	assign wr_ctrl = wr && adr_i == `OFS_TIME_BASE_CONTROL;
	assign wr_count = wr && adr_i == `OFS_TIME_BASE_COUNT;
	assign wr_period = wr && adr_i == `OFS_TIME_BASE_PERIOD;
	assign wr_cmp = wr && adr_i == `OFS_EVENT_TRIGGER_COMPARE;
	assign wr_pincfg = wr && adr_i == `OFS_PAIR_MODE_AND_PIN_ENABLE;
	assign wr_upd = wr && adr_i == `OFS_UPDATE_AND_TRIGGER_CONTROL;
	assign wr_ovr = wr && adr_i == `OFS_MANUAL_OVERRIDE_CONTROL;
	assign mode = motor_pwm_pkg::count_mode_t'(ctrl_q[`POS_COUNT_MODE +: 2]);

	// (RULE_18) Enable and idle halt.
	assign run = ctrl_q[`BIT_COUNT_ENABLE] && !(ctrl_q[`BIT_HALT_IN_IDLE] && idle_i);

	// (RULE_20) Input prescale select.
	always_comb begin
		case (ctrl_q[`POS_INPUT_PRESCALE +: 2])
			2'h0: pre_limit = `PRESCALE_LIMIT_1;
			2'h1: pre_limit = `PRESCALE_LIMIT_4;
			2'h2: pre_limit = `PRESCALE_LIMIT_16;
			default: pre_limit = `PRESCALE_LIMIT_64;
		endcase
	end

	assign tb_tick = run && phase_q && pre_q == pre_limit;
	assign at_top = tb_tick && !dir_q && count_q >= period_act_q;
	assign at_bot = tb_tick && dir_q && count_q == 15'h0000;

	// (RULE_03) Update boundary per mode.
	always_comb begin
		case (mode)
			motor_pwm_pkg::MODE_UP_DOWN: boundary = at_bot;
			motor_pwm_pkg::MODE_UP_DOWN_DOUBLE: boundary = at_top || at_bot;
			default: boundary = at_top;
		endcase
	end

	// (RULE_07) Compare match (RULE_08) with direction.
	assign sev_match = tb_tick && count_q == cmp_q[14:0] && dir_q == cmp_q[`BIT_TRIGGER_DIRECTION];

	// (RULE_01) Half-cycle phase and prescaler.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_q <= 1'b0;
			pre_q <= 6'h00;
		end else begin
			phase_q <= !phase_q;
			if (!run) begin
				pre_q <= 6'h00;
			end else if (phase_q) begin
				pre_q <= (pre_q == pre_limit) ? 6'h00 : 6'(pre_q + 6'h01);
			end
		end
	end

	// (RULE_18) Control register; single event clears enable, a write wins.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= `RST_TIME_BASE_CONTROL;
		end else if (wr_ctrl) begin
			ctrl_q <= merge(ctrl_q, dat_i, sel_i) & `MASK_TIME_BASE_CONTROL;
		end else if (mode == motor_pwm_pkg::MODE_SINGLE_EVENT && at_top) begin
			ctrl_q[`BIT_COUNT_ENABLE] <= 1'b0;
		end
	end

	// (RULE_04) Count value (RULE_19) stepped per mode.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_q <= 15'h0000;
			dir_q <= 1'b0;
		end else if (wr_count) begin
			count_q <= 15'(merge({1'b0, count_q}, dat_i, sel_i) & `MASK_TIME_BASE_PERIOD);
		end else if (tb_tick) begin
			if (mode == motor_pwm_pkg::MODE_FREE_RUN || mode == motor_pwm_pkg::MODE_SINGLE_EVENT) begin
				dir_q <= 1'b0;
				count_q <= at_top ? 15'h0000 : 15'(count_q + 15'h0001);
			end else if (!dir_q) begin
				if (at_top) begin
					dir_q <= 1'b1;
					count_q <= (count_q == 15'h0000) ? 15'h0000 : 15'(count_q - 15'h0001);
				end else begin
					count_q <= 15'(count_q + 15'h0001);
				end
			end else if (at_bot) begin
				dir_q <= 1'b0;
				count_q <= 15'h0001;
			end else begin
				count_q <= 15'(count_q - 15'h0001);
			end
		end
	end

	// (RULE_06) Period buffer (RULE_14) copied unless blocked.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			period_buf_q <= `RST_TIME_BASE_PERIOD;
			period_act_q <= 15'h0000;
		end else begin
			if (wr_period) begin
				period_buf_q <= merge(period_buf_q, dat_i, sel_i) & `MASK_TIME_BASE_PERIOD;
			end
			if (!upd_q[`BIT_BUFFER_TRANSFER_BLOCK] && (boundary || !run)) begin
				period_act_q <= period_buf_q[14:0];
			end
		end
	end

	// (RULE_10) Compare, pair mode (RULE_12) pin enables from configuration.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmp_q <= `RST_EVENT_TRIGGER_COMPARE;
			pincfg_q <= {8'h00, {8{boot_config_word_i.pins_to_pwm}}};
			upd_q <= `RST_UPDATE_AND_TRIGGER_CONTROL;
		end else begin
			if (wr_cmp) begin
				cmp_q <= merge(cmp_q, dat_i, sel_i);
			end
			if (wr_pincfg) begin
				pincfg_q <= merge(pincfg_q, dat_i, sel_i) & `MASK_PAIR_MODE_AND_PIN_ENABLE;
			end
			if (wr_upd) begin
				upd_q <= merge(upd_q, dat_i, sel_i) & `MASK_UPDATE_AND_TRIGGER_CONTROL;
			end
		end
	end

	// (RULE_16) Override register (RULE_21) applied now or at the boundary.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ovr_q <= `RST_MANUAL_OVERRIDE_CONTROL;
			ovr_act_q <= `RST_MANUAL_OVERRIDE_CONTROL;
		end else begin
			if (wr_ovr) begin
				ovr_q <= merge(ovr_q, dat_i, sel_i);
			end
			if (!upd_q[`BIT_OVERRIDE_SYNC] || boundary) begin
				ovr_act_q <= ovr_q;
			end
		end
	end

	// (RULE_20) Postscalers for the boundary event (RULE_09) and converter trigger.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tb_post_q <= 4'h0;
			sev_post_q <= 4'h0;
			adc_q <= 1'b0;
			per_evt_q <= 1'b0;
		end else begin
			adc_q <= 1'b0;
			per_evt_q <= 1'b0;
			if (boundary) begin
				if (tb_post_q >= ctrl_q[`POS_INTERRUPT_POSTSCALE +: 4]) begin
					tb_post_q <= 4'h0;
					per_evt_q <= 1'b1;
				end else begin
					tb_post_q <= 4'(tb_post_q + 4'h1);
				end
			end
			if (sev_match) begin
				if (sev_post_q >= upd_q[`POS_TRIGGER_POSTSCALE +: 4]) begin
					sev_post_q <= 4'h0;
					adc_q <= 1'b1;
				end else begin
					sev_post_q <= 4'(sev_post_q + 4'h1);
				end
			end
		end
	end

	// (RULE_17) One generator per pair, three or four.
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gen_pair
			logic gen_h;
			logic gen_l;
			logic act_h;
			logic act_l;
			assign wr_duty[g] = wr && adr_i == 8'(`OFS_DUTY_BASE + 4 * g);

			// (RULE_01) Half-cycle duty compare.
			assign gen_h = (g < NUM_GEN) && ({count_q, phase_q} < duty_act_q[g]);
			// (RULE_02) Complementary or (RULE_10) independent low pin.
			assign gen_l = pincfg_q[`POS_PAIR_INDEPENDENT_SELECT + g] ? gen_h : !gen_h;
			// (RULE_16) Override replaces generator output.
			assign act_h = ovr_act_q[`POS_OVERRIDE_ENABLE + 2 * g + 1] ? gen_h : ovr_act_q[2 * g + 1];
			assign act_l = ovr_act_q[`POS_OVERRIDE_ENABLE + 2 * g] ? gen_l : ovr_act_q[2 * g];

			// (RULE_15) Immediate or (RULE_14) blockable buffered duty update.
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					duty_buf_q[g] <= `RST_DUTY;
					duty_act_q[g] <= `RST_DUTY;
				end else begin
					if (wr_duty[g]) begin
						duty_buf_q[g] <= merge(duty_buf_q[g], dat_i, sel_i);
					end
					if (wr_duty[g] && upd_q[`BIT_IMMEDIATE_DUTY_UPDATE]) begin
						duty_act_q[g] <= merge(duty_buf_q[g], dat_i, sel_i);
					end else if (!upd_q[`BIT_BUFFER_TRANSFER_BLOCK] && (boundary || !run)) begin
						duty_act_q[g] <= duty_buf_q[g];
					end
				end
			end

			// (RULE_13) Polarity and reset state (RULE_11) with pin ownership.
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					level_q.high[g] <= !boot_config_word_i.high_active_high;
					level_q.low[g] <= !boot_config_word_i.low_active_high;
					own_q.high[g] <= boot_config_word_i.pins_to_pwm && (g < NUM_GEN);
					own_q.low[g] <= boot_config_word_i.pins_to_pwm && (g < NUM_GEN);
				end else begin
					level_q.high[g] <= (act_h && own_q.high[g]) ~^ boot_config_word_i.high_active_high;
					level_q.low[g] <= (act_l && own_q.low[g]) ~^ boot_config_word_i.low_active_high;
					own_q.high[g] <= pincfg_q[`POS_HIGH_PIN_ENABLE + g] && (g < NUM_GEN);
					own_q.low[g] <= pincfg_q[`POS_LOW_PIN_ENABLE + g] && (g < NUM_GEN);
				end
			end
		end
	endgenerate

	// (RULE_05) Direction in count top bit (RULE_06) period top bit zero.
	always_comb begin
		rd_word = 16'h0000;
		case (adr_i)
			`OFS_TIME_BASE_CONTROL: rd_word = ctrl_q;
			`OFS_TIME_BASE_COUNT: rd_word = {dir_q, count_q};
			`OFS_TIME_BASE_PERIOD: rd_word = {1'b0, period_buf_q[14:0]};
			`OFS_EVENT_TRIGGER_COMPARE: rd_word = cmp_q;
			`OFS_PAIR_MODE_AND_PIN_ENABLE: rd_word = pincfg_q;
			`OFS_UPDATE_AND_TRIGGER_CONTROL: rd_word = upd_q;
			`OFS_MANUAL_OVERRIDE_CONTROL: rd_word = ovr_q;
			default: begin
				for (int i = 0; i < 4; i++) begin
					if (adr_i == 8'(`OFS_DUTY_BASE + 4 * i)) begin
						rd_word = duty_buf_q[i];
					end
				end
			end
		endcase
	end

	// Bus answer, one cycle after the request.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h00000000;
		end else begin
			ack_q <= req;
			if (req && !we_i) begin
				dat_q <= {16'h0000, rd_word};
			end
		end
	end

	assign ack_o = ack_q;
	assign dat_o = dat_q;
	assign pin_level_o = level_q;
	assign pin_own_o = own_q;
	assign adc_trigger_o = adc_q;
	assign period_event_o = per_evt_q;

	property p_trig_fire;
		@(posedge clk_i) disable iff (rst_i)
		(sev_match && upd_q[11:8] == 4'h0) |=> adc_trigger_o;
	endproperty
	a_trig_fire: assert property (p_trig_fire) else $error("trigger missed"); // RULE_07

	property p_trig_dir;
		@(posedge clk_i) disable iff (rst_i)
		adc_trigger_o |-> $past(dir_q) == $past(cmp_q[15]);
	endproperty
	a_trig_dir: assert property (p_trig_dir) else $error("trigger wrong direction"); // RULE_08

	property p_dir_read;
		@(posedge clk_i) disable iff (rst_i)
		(req && !we_i && adr_i == 8'h04) |=> ack_o && dat_o[15] == $past(dir_q);
	endproperty
	a_dir_read: assert property (p_dir_read) else $error("direction not read back"); // RULE_05

	property p_period_top;
		@(posedge clk_i) disable iff (rst_i)
		(req && !we_i && adr_i == 8'h08) |=> dat_o[15] == 1'b0;
	endproperty
	a_period_top: assert property (p_period_top) else $error("period top bit set"); // RULE_06

	property p_free_wrap;
		@(posedge clk_i) disable iff (rst_i)
		(ctrl_q[1:0] == 2'h0 && at_top && !wr_count) |=> count_q == 15'h0000;
	endproperty
	a_free_wrap: assert property (p_free_wrap) else $error("free run did not wrap"); // RULE_19

	property p_stopped;
		@(posedge clk_i) disable iff (rst_i)
		(!run && !wr_count) |=> $stable(count_q);
	endproperty
	a_stopped: assert property (p_stopped) else $error("counted while stopped"); // RULE_18

	property p_block;
		@(posedge clk_i) disable iff (rst_i)
		upd_q[0] |=> $stable(period_act_q);
	endproperty
	a_block: assert property (p_block) else $error("period moved while blocked"); // RULE_14

	property p_immediate;
		@(posedge clk_i) disable iff (rst_i)
		(wr_duty[0] && upd_q[2]) |=> duty_act_q[0] == duty_buf_q[0];
	endproperty
	a_immediate: assert property (p_immediate) else $error("duty not immediate"); // RULE_15

	property p_release;
		@(posedge clk_i) disable iff (rst_i)
		(!pincfg_q[4] && !wr_pincfg) |=> ##1 !pin_own_o.high[0];
	endproperty
	a_release: assert property (p_release) else $error("pin not released"); // RULE_11

	c_trigger: cover property (@(posedge clk_i) disable iff (rst_i) adc_trigger_o);
	c_single_end: cover property (@(posedge clk_i) disable iff (rst_i)
		ctrl_q[1:0] == 2'h1 && at_top);
	c_double_bot: cover property (@(posedge clk_i) disable iff (rst_i)
		ctrl_q[1:0] == 2'h3 && at_bot);

endmodule : motor_pwm_time_base

/* File: motor_pwm_params.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the PWM time base.
// Assumes: Wishbone byte addressing, one 16-bit register per 32-bit word.
// Notes: Definitions only.
`ifndef MOTOR_PWM_PARAMS_SVH
`define MOTOR_PWM_PARAMS_SVH

`define OFS_TIME_BASE_CONTROL 8'h00
`define OFS_TIME_BASE_COUNT 8'h04
`define OFS_TIME_BASE_PERIOD 8'h08
`define OFS_EVENT_TRIGGER_COMPARE 8'h0C
`define OFS_PAIR_MODE_AND_PIN_ENABLE 8'h10
`define OFS_UPDATE_AND_TRIGGER_CONTROL 8'h14
`define OFS_MANUAL_OVERRIDE_CONTROL 8'h18
`define OFS_DUTY_BASE 8'h1C

`define RST_TIME_BASE_CONTROL 16'h0000
`define RST_TIME_BASE_PERIOD 16'h0000
`define RST_EVENT_TRIGGER_COMPARE 16'h0000
`define RST_UPDATE_AND_TRIGGER_CONTROL 16'h0000
`define RST_MANUAL_OVERRIDE_CONTROL 16'hFF00
`define RST_DUTY 16'h0000

`define MASK_TIME_BASE_CONTROL 16'hA0FF
`define MASK_TIME_BASE_PERIOD 16'h7FFF
`define MASK_PAIR_MODE_AND_PIN_ENABLE 16'h0FFF
`define MASK_UPDATE_AND_TRIGGER_CONTROL 16'h0F07

`define BIT_COUNT_ENABLE 15
`define BIT_HALT_IN_IDLE 13
`define POS_INTERRUPT_POSTSCALE 4
`define POS_INPUT_PRESCALE 2
`define POS_COUNT_MODE 0
`define BIT_COUNT_DIRECTION 15
`define BIT_TRIGGER_DIRECTION 15
`define POS_PAIR_INDEPENDENT_SELECT 8
`define POS_HIGH_PIN_ENABLE 4
`define POS_LOW_PIN_ENABLE 0
`define POS_TRIGGER_POSTSCALE 8
`define BIT_IMMEDIATE_DUTY_UPDATE 2
`define BIT_OVERRIDE_SYNC 1
`define BIT_BUFFER_TRANSFER_BLOCK 0
`define POS_OVERRIDE_ENABLE 8

`define CLKS_PER_INSTRUCTION 2
`define PRESCALE_LIMIT_1 6'h00
`define PRESCALE_LIMIT_4 6'h03
`define PRESCALE_LIMIT_16 6'h0F
`define PRESCALE_LIMIT_64 6'h3F

`endif

/* File: motor_pwm_pkg.sv */
// Purpose: Types shared by the PWM time base and its users.
// Assumes: Four pin pairs at most.
// Notes: Offsets and counts live in motor_pwm_params.svh.
package motor_pwm_pkg;

	typedef enum logic [1:0] {
		MODE_FREE_RUN = 2'h0,
		MODE_SINGLE_EVENT = 2'h1,
		MODE_UP_DOWN = 2'h2,
		MODE_UP_DOWN_DOUBLE = 2'h3
	} count_mode_t;

	typedef struct packed {
		logic pins_to_pwm;
		logic high_active_high;
		logic low_active_high;
	} boot_config_word_t;

	typedef struct packed {
		logic [3:0] high;
		logic [3:0] low;
	} pin_pair_t;

endpackage : motor_pwm_pkg

/* File: motor_bridge_model.sv */
// Purpose: Bridge leg switches driven by the PWM pins.
// Assumes: A switch conducts while its pin is owned and at its active level.
// Notes: Counts cycles in which both switches of one leg conduct.
`timescale 1ns/100ps
module motor_bridge_model (
	// Clock.
	input wire logic clk_i,
	// Pins from the PWM block.
	input wire motor_pwm_pkg::pin_pair_t pin_level_i,
	input wire motor_pwm_pkg::pin_pair_t pin_own_i,
	input wire motor_pwm_pkg::boot_config_word_t boot_config_word_i,
	// Leg state.
	output logic [3:0] phase_o,
	output int shoot_o
);
	logic [3:0] on_high;
	logic [3:0] on_low;
	assign on_high = pin_own_i.high & ~(pin_level_i.high ^ {4{boot_config_word_i.high_active_high}});
	assign on_low = pin_own_i.low & ~(pin_level_i.low ^ {4{boot_config_word_i.low_active_high}});
	initial begin
		shoot_o = 0;
		phase_o = 4'h0;
		forever begin
			@(posedge clk_i);
			if ((on_high & on_low) != 4'h0) shoot_o = shoot_o + 1;
			phase_o = (phase_o & ~on_low) | on_high;
		end
	end
endmodule : motor_bridge_model

/* File: motor_pwm_time_base_control_tb_top.sv */
// Purpose: Self-checking bench for the PWM time base.
// Assumes: Wishbone classic master, active high polarity in the first run.
// Notes: Random values from a fixed seed.
`timescale 1ns/100ps
`include "motor_pwm_params.svh"
module motor_pwm_time_base_control_tb_top;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, idle_i, ack_o, adc_trigger_o, period_event_o;
	logic [7:0] adr_i;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o;
	logic [3:0] phase;
	motor_pwm_pkg::boot_config_word_t boot_i;
	motor_pwm_pkg::pin_pair_t pin_level_o, pin_own_o;
	int shoot, errors, n_compared, g, o1, o2, i, m, pr, po, s0;
	logic [15:0] q, r, p, c;
	logic [7:0] ofs [0:6] = '{`OFS_TIME_BASE_CONTROL, `OFS_TIME_BASE_PERIOD,
		`OFS_EVENT_TRIGGER_COMPARE, `OFS_PAIR_MODE_AND_PIN_ENABLE,
		`OFS_UPDATE_AND_TRIGGER_CONTROL, `OFS_MANUAL_OVERRIDE_CONTROL, `OFS_DUTY_BASE};
	logic [15:0] msk [0:6] = '{16'hA0FF, 16'h7FFF, 16'hFFFF, 16'h0FFF, 16'h0F07, 16'hFFFF, 16'hFFFF};
	logic [15:0] rstv [0:6] = '{16'h0000, 16'h0000, 16'h0000, 16'h00FF, 16'h0000, 16'hFF00, 16'h0000};

	motor_pwm_time_base #(.NUM_GEN(4)) DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
		.ack_o(ack_o), .idle_i(idle_i), .boot_config_word_i(boot_i), .pin_level_o(pin_level_o),
		.pin_own_o(pin_own_o), .adc_trigger_o(adc_trigger_o), .period_event_o(period_event_o));
	motor_bridge_model bridge (.clk_i(clk_i), .pin_level_i(pin_level_o), .pin_own_i(pin_own_o),
		.boot_config_word_i(boot_i), .phase_o(phase), .shoot_o(shoot));

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	task automatic test_done();
		$display("Compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : test_done

	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_val

	task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_pin

	task automatic wb(input logic [7:0] a, input logic w, input logic [15:0] d,
		output logic [15:0] rq);
		int k;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= 4'hF;
		dat_i <= {16'h0000, d};
		for (k = 0; k < 20; k++) begin
			@(posedge clk_i);
			if (ack_o === 1'b1) break;
		end
		if (k == 20) begin
			errors++;
			test_done();
		end
		rq = dat_o[15:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] x;
		wb(a, 1'b1, d, x);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [15:0] x);
		wb(a, 1'b0, 16'h0000, x);
	endtask : rd

	task automatic wait_pulse(input int w, output int n);
		for (n = 1; n <= 4000; n++) begin
			@(negedge clk_i);
			if ((w == 0 ? period_event_o : adc_trigger_o) === 1'b1) return;
		end
		errors++;
		test_done();
	endtask : wait_pulse

	task automatic meas(input int w, output int n);
		wait_pulse(w, n);
		wait_pulse(w, n);
		wait_pulse(w, n);
	endtask : meas

	task automatic offs(output int o);
		int n;
		wait_pulse(0, n);
		wait_pulse(1, o);
	endtask : offs

	function automatic int exp_gap(input int md, input int pre, input int post, input int per);
		int steps;
		steps = (md == 0) ? per + 1 : (md == 2) ? 2 * per : per;
		return steps * 2 * (1 << (2 * pre)) * (post + 1);
	endfunction : exp_gap

	function automatic logic [7:0] exp_pins(input logic [7:0] v);
		return {v[7], v[5], v[3], v[1], v[6], v[4], v[2], v[0]};
	endfunction : exp_pins

	initial begin
		{cyc_i, stb_i, we_i, idle_i, adr_i, sel_i, dat_i} = '0;
		rst_i = 1'b1;
		boot_i = 3'b111;
		errors = 0;
		n_compared = 0;
		void'($urandom(32'h9FFB));
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk_pin(pin_own_o, 8'hFF);
		for (i = 0; i < 7; i++) begin
			rd(ofs[i], q);
			chk_val(q, rstv[i]);
			r = 16'($urandom) & ((i == 0) ? 16'h7FFF : 16'hFFFF);
			wr(ofs[i], r);
			rd(ofs[i], q);
			chk_val(q, r & msk[i]);
		end
		wr(`OFS_TIME_BASE_CONTROL, 16'h0000);
		r = 16'($urandom);
		wr(`OFS_TIME_BASE_COUNT, r);
		rd(`OFS_TIME_BASE_COUNT, q);
		chk_val(q, {1'b0, r[14:0]});
		wr(8'h3C, r);
		rd(8'h3C, q);
		chk_val(q, 16'h0000);
		r = 16'($urandom);
		wr(`OFS_PAIR_MODE_AND_PIN_ENABLE, {8'h00, r[7:0]});
		repeat (3) @(negedge clk_i);
		chk_pin(pin_own_o, r[7:0]);
		wr(`OFS_PAIR_MODE_AND_PIN_ENABLE, 16'h00FF);
		wr(`OFS_UPDATE_AND_TRIGGER_CONTROL, 16'h0000);
		wr(`OFS_MANUAL_OVERRIDE_CONTROL, 16'h00A5);
		repeat (3) @(negedge clk_i);
		chk_pin(pin_level_o, exp_pins(8'hA5));
		wr(`OFS_UPDATE_AND_TRIGGER_CONTROL, 16'h0002);
		wr(`OFS_MANUAL_OVERRIDE_CONTROL, 16'h005A);
		repeat (10) @(negedge clk_i);
		chk_pin(pin_level_o, exp_pins(8'hA5));
		wr(`OFS_TIME_BASE_PERIOD, 16'h0003);
		wr(`OFS_TIME_BASE_CONTROL, 16'h8000);
		meas(0, g);
		repeat (3) @(negedge clk_i);
		chk_pin(pin_level_o, exp_pins(8'h5A));
		wr(`OFS_UPDATE_AND_TRIGGER_CONTROL, 16'h0000);
		wr(`OFS_MANUAL_OVERRIDE_CONTROL, 16'hFF00);
		for (i = 0; i < 4; i++) wr(`OFS_DUTY_BASE + 8'(4 * i), 16'($urandom_range(1, 7)));
		s0 = shoot;
		repeat (40) begin
			@(negedge clk_i);
			chk_pin({4'h0, pin_level_o.high}, {4'h0, ~pin_level_o.low});
		end
		chk_val(16'(shoot - s0), 16'h0000);
		wr(`OFS_PAIR_MODE_AND_PIN_ENABLE, 16'h0FFF);
		repeat (40) begin
			@(negedge clk_i);
			chk_pin({4'h0, pin_level_o.high}, {4'h0, pin_level_o.low});
		end
		for (i = 0; i < 7; i++) begin
			m = (i % 3 == 0) ? 0 : (i % 3 == 1) ? 2 : 3;
			pr = i >> 1;
			po = $urandom_range(0, 3);
			p = 16'($urandom_range(2, 6));
			wr(`OFS_TIME_BASE_CONTROL, 16'h0000);
			wr(`OFS_TIME_BASE_COUNT, 16'h0000);
			wr(`OFS_TIME_BASE_PERIOD, p);
			wr(`OFS_TIME_BASE_CONTROL, 16'(32'h8000 + po * 16 + pr * 4 + m));
			meas(0, g);
			chk_val(16'(g), 16'(exp_gap(m, pr, po, int'(p))));
		end
		wr(`OFS_TIME_BASE_CONTROL, 16'h0000);
		wr(`OFS_TIME_BASE_COUNT, 16'h0000);
		wr(`OFS_TIME_BASE_PERIOD, 16'h0003);
		wr(`OFS_TIME_BASE_CONTROL, 16'h8001);
		wait_pulse(0, g);
		repeat (2) @(negedge clk_i);
		rd(`OFS_TIME_BASE_CONTROL, q);
		chk_val(q, 16'h0001);
		@(posedge clk_i);
		idle_i <= 1'b1;
		wr(`OFS_TIME_BASE_COUNT, 16'h0000);
		wr(`OFS_TIME_BASE_CONTROL, 16'hA000);
		repeat (20) @(negedge clk_i);
		rd(`OFS_TIME_BASE_COUNT, q);
		chk_val(q, 16'h0000);
		@(posedge clk_i);
		idle_i <= 1'b0;
		meas(0, g);
		chk_val(16'(g), 16'h0008);
		wr(`OFS_UPDATE_AND_TRIGGER_CONTROL, 16'h0001);
		wr(`OFS_TIME_BASE_PERIOD, 16'h0005);
		meas(0, g);
		chk_val(16'(g), 16'h0008);
		wr(`OFS_UPDATE_AND_TRIGGER_CONTROL, 16'h0000);
		meas(0, g);
		chk_val(16'(g), 16'h000C);
		wr(`OFS_TIME_BASE_CONTROL, 16'h0000);
		wr(`OFS_TIME_BASE_COUNT, 16'h0000);
		wr(`OFS_TIME_BASE_PERIOD, 16'h0008);
		c = 16'($urandom_range(2, 6));
		wr(`OFS_EVENT_TRIGGER_COMPARE, c);
		wr(`OFS_TIME_BASE_CONTROL, 16'h8002);
		offs(o1);
		offs(o1);
		wr(`OFS_EVENT_TRIGGER_COMPARE, 16'h8000 | c);
		offs(o2);
		offs(o2);
		chk_val(16'(o2 - o1), 16'(4 * (8 - int'(c))));
		po = $urandom_range(0, 3);
		wr(`OFS_UPDATE_AND_TRIGGER_CONTROL, 16'(po * 256));
		meas(1, g);
		chk_val(16'(g), 16'(32 * (po + 1)));
		wr(`OFS_UPDATE_AND_TRIGGER_CONTROL, 16'h0005);
		wr(`OFS_DUTY_BASE, 16'hFFFF);
		repeat (40) begin
			@(negedge clk_i);
			chk_pin({7'h00, pin_level_o.high[0]}, 8'h01);
		end
		@(posedge clk_i);
		rst_i <= 1'b1;
		boot_i <= 3'b001;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk_pin(pin_own_o, 8'h00);
		chk_pin(pin_level_o, 8'hF0);
		rd(`OFS_PAIR_MODE_AND_PIN_ENABLE, q);
		chk_val(q, 16'h0000);
		test_done();
	end
endmodule : motor_pwm_time_base_control_tb_top
